// ==== sbhvb_pkg.sv ====
// register map, event codes, power modes and carrier types of the link controller
// shared by the vector and buffer logic; assumes a 32-bit AXI4-Lite register bus
package sbhvb_pkg;

    // ==========================================================
    // register map: word indices, byte address is four times
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_EVENT_VECTOR = 10'h03E;
    localparam logic [9:0] IDX_BYTE_BUFFER = 10'h03F;
    localparam logic [9:0] IDX_CONTROL = 10'h040;
    localparam logic [9:0] IDX_STATUS = 10'h041;

    // ==========================================================
    // field positions and reset values
    // ==========================================================
    localparam int CTL_IRQ_ALLOW = 0;
    localparam int CTL_WAIT_CLOCK_MODE = 1;
    localparam int CTL_TX_END_OF_DATA = 2;
    localparam int VEC_CODE_LSB = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // event codes, ascending priority
    // ==========================================================
    localparam logic [3:0] EV_NONE = 4'h0;
    localparam logic [3:0] EV_EOF = 4'h1;
    localparam logic [3:0] EV_RESP_BYTE = 4'h2;
    localparam logic [3:0] EV_RX_FULL = 4'h3;
    localparam logic [3:0] EV_TX_EMPTY = 4'h4;
    localparam logic [3:0] EV_ARB_LOST = 4'h5;
    localparam logic [3:0] EV_CRC_ERR = 4'h6;
    localparam logic [3:0] EV_SYMBOL = 4'h7;
    localparam logic [3:0] EV_WAKE = 4'h8;
    localparam int EV_COUNT = 8;

    // ==========================================================
    // power modes and carriers
    // ==========================================================
    typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP, PM_RESTART} sbhvb_mode_t;

    // reports from the bit-level engine, one-cycle pulses except rx_byte and its qualifier rx_is_response
    typedef struct packed {
        logic rx_byte_valid;
        logic rx_is_response;
        logic [7:0] rx_byte;
        logic rx_eof;
        logic arb_lost;
        logic crc_err;
        logic symbol_err;
        logic tx_first_bit;
        logic tx_byte_done;
    } sbhvb_link_ev_t;

    // commands to the bit-level engine
    typedef struct packed {
        logic load;
        logic [7:0] data;
        logic enable;
        logic underrun;
    } sbhvb_tx_cmd_t;

endpackage : sbhvb_pkg

// ==== sbhvb_link_controller.sv ====
// state vector, double-buffered byte buffer and low-power control of the link controller
// assumes a bit-level engine beside it that shifts symbols and reports events in one cycle
//
// How it works
// - read-only vector, code in bits 5..2, other bits zero, resets zero
// - codes one to eight: eof, response, rx full, tx empty, arb, crc, symbol, wake
// - vector read clears the reported source, except the three buffer conditions
// - rx full and response clear after vector read then buffer read
// - tx empty clears after vector read then buffer write, or end-of-data
// - cleared higher source at once exposes the next lower pending source
// - vector reads as four times the code, a jump-table index
// - buffer writes feed the transmitter, reads return the last received byte
// - finished shift register reloads from the transmit shadow byte
// - tx empty sets once the shift register sent its first bit
// - whole received byte goes to receive shadow and sets rx full, or response for a response byte
// - missing data is an underrun; transmitter stops past a byte boundary
// - underrun is reported as an invalid symbol event
// - wait with clock mode clear keeps clocks and drives nothing
// - received message wakes from wait, interrupt if allowed, message kept
// - stop instruction, or wait with clock mode set, enters stop
// - in stop a passive-to-active bus edge wakes with non-maskable interrupt
// - stop through wait keeps the waking byte only if eof came before
// - stop during reception wakes on first edge, then waits for stable clocks
`timescale 1ns/1ps

module sbhvb_link_controller #(
    parameter int ADDR_W = sbhvb_pkg::ADDR_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // bit-level engine
    input wire sbhvb_pkg::sbhvb_link_ev_t link_ev,
    input wire logic bus_active,
    output sbhvb_pkg::sbhvb_tx_cmd_t tx_cmd,
    // cpu and clock system
    input wire logic cpu_wait_exec,
    input wire logic cpu_stop_exec,
    input wire logic clocks_stable,
    output logic cpu_irq,
    output logic cpu_nmi,
    output logic wake_rx_ok
);

    // ==========================================================
    // helper functions
    // ==========================================================
    // highest pending source wins
    function automatic logic [3:0] sbhvb_top_code(input logic [8:1] p);
        logic [3:0] c;
        c = sbhvb_pkg::EV_NONE;
        for (int i = 1; i <= sbhvb_pkg::EV_COUNT; i++)
        begin
            if (p[i])
                c = 4'(i);
        end
        return c;
    endfunction : sbhvb_top_code

    function automatic logic [8:1] sbhvb_onehot(input logic [3:0] c);
        logic [8:1] m;
        m = '0;
        for (int i = 1; i <= sbhvb_pkg::EV_COUNT; i++)
        begin
            if (c == 4'(i))
                m[i] = 1'b1;
        end
        return m;
    endfunction : sbhvb_onehot

    // ==========================================================
    // state
    // ==========================================================
    logic [8:1] pend;
    logic [3:0] armed;
    logic [7:0] rx_shadow;
    logic [7:0] tx_shadow;
    logic shadow_full;
    logic tx_active;
    logic tx_end_of_data_pending;
    logic irq_allow;
    logic wait_clock_mode;
    logic eof_seen;
    logic bus_prev;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    sbhvb_pkg::sbhvb_mode_t mode;
    sbhvb_pkg::sbhvb_mode_t next_mode;

    // ==========================================================
    // bus decode
    // ==========================================================
    wire [3:0] code = sbhvb_top_code(pend);
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [9:0] wr_idx = aw_addr[11:2];
    wire [9:0] rd_idx = s_axi_araddr[11:2];
    wire wr_lane = w_strb[0];
    wire wr_buf = do_write && wr_lane && wr_idx == sbhvb_pkg::IDX_BYTE_BUFFER;
    wire wr_ctl = do_write && wr_lane && wr_idx == sbhvb_pkg::IDX_CONTROL;
    wire wr_hit = wr_idx == sbhvb_pkg::IDX_BYTE_BUFFER || wr_idx == sbhvb_pkg::IDX_CONTROL
        || wr_idx == sbhvb_pkg::IDX_EVENT_VECTOR || wr_idx == sbhvb_pkg::IDX_STATUS;
    wire rd_vec = do_read && rd_idx == sbhvb_pkg::IDX_EVENT_VECTOR;
    wire rd_buf = do_read && rd_idx == sbhvb_pkg::IDX_BYTE_BUFFER;
    wire tx_end_of_data_set = wr_ctl && w_data[sbhvb_pkg::CTL_TX_END_OF_DATA];

    // read data selection; vector is code times four
    logic [31:0] rd_value;
    logic rd_hit;
    always_comb
    begin
        rd_value = '0;
        rd_hit = 1'b1;
        if (rd_idx == sbhvb_pkg::IDX_EVENT_VECTOR)
            rd_value = {24'h000000, 2'h0, code, 2'h0};
        else if (rd_idx == sbhvb_pkg::IDX_BYTE_BUFFER)
            rd_value = {24'h000000, rx_shadow};
        else if (rd_idx == sbhvb_pkg::IDX_CONTROL)
            rd_value = {29'h00000000, tx_end_of_data_pending, wait_clock_mode, irq_allow};
        else if (rd_idx == sbhvb_pkg::IDX_STATUS)
            rd_value = {26'h0000000, mode, eof_seen, tx_active, shadow_full, wake_rx_ok};
        else
            rd_hit = 1'b0;
    end

    // ==========================================================
    // event flags; a set in the clearing cycle wins
    // ==========================================================
    wire underrun = link_ev.tx_byte_done && tx_active && !shadow_full && !tx_end_of_data_pending;
    wire bus_rise = bus_active && !bus_prev;
    wire stop_wake = mode == sbhvb_pkg::PM_STOP && bus_rise;
    wire vec_keeps = code == sbhvb_pkg::EV_RESP_BYTE || code == sbhvb_pkg::EV_RX_FULL
        || code == sbhvb_pkg::EV_TX_EMPTY;
    logic [8:1] ev_set;
    logic [8:1] ev_clr;
    always_comb
    begin
        ev_set = '0;
        ev_set[sbhvb_pkg::EV_EOF] = link_ev.rx_eof;
        ev_set[sbhvb_pkg::EV_RESP_BYTE] = link_ev.rx_byte_valid && link_ev.rx_is_response;
        ev_set[sbhvb_pkg::EV_RX_FULL] = link_ev.rx_byte_valid && !link_ev.rx_is_response;
        ev_set[sbhvb_pkg::EV_TX_EMPTY] = link_ev.tx_first_bit;
        ev_set[sbhvb_pkg::EV_ARB_LOST] = link_ev.arb_lost;
        ev_set[sbhvb_pkg::EV_CRC_ERR] = link_ev.crc_err;
        ev_set[sbhvb_pkg::EV_SYMBOL] = link_ev.symbol_err || underrun;
        ev_set[sbhvb_pkg::EV_WAKE] = stop_wake;
        ev_clr = '0;
        if (rd_vec && !vec_keeps)
            ev_clr = sbhvb_onehot(code);
        if (rd_buf && (armed == sbhvb_pkg::EV_RX_FULL || armed == sbhvb_pkg::EV_RESP_BYTE))
            ev_clr = ev_clr | sbhvb_onehot(armed);
        if (wr_buf && armed == sbhvb_pkg::EV_TX_EMPTY)
            ev_clr[sbhvb_pkg::EV_TX_EMPTY] = 1'b1;
        if (tx_end_of_data_set)
            ev_clr[sbhvb_pkg::EV_TX_EMPTY] = 1'b1;
    end

    // flags hold until cleared; priority is recomputed every cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pend <= '0;
        else
            pend <= (pend & ~ev_clr) | ev_set;
    end

    // a buffer condition reported by the vector waits for its data access;
    // end-of-data disarms too, so a later first write cannot clear tx empty unread
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            armed <= sbhvb_pkg::EV_NONE;
        else if (rd_vec && vec_keeps)
            armed <= code;
        else if (rd_buf || wr_buf || tx_end_of_data_set)
            armed <= sbhvb_pkg::EV_NONE;
    end

    // ==========================================================
    // receive shadow; a late reader loses the older byte
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_shadow <= sbhvb_pkg::RST_BYTE;
        else if (link_ev.rx_byte_valid)
            rx_shadow <= link_ev.rx_byte;
    end

    // ==========================================================
    // transmit shadow and shift register handoff
    // ==========================================================
    wire shift_free = link_ev.tx_byte_done || !tx_active;
    wire load_now = shift_free && shadow_full && mode == sbhvb_pkg::PM_RUN;
    wire next_active = load_now || (tx_active && !link_ev.tx_byte_done);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_shadow <= sbhvb_pkg::RST_BYTE;
            shadow_full <= 1'b0;
            tx_active <= 1'b0;
            tx_end_of_data_pending <= 1'b0;
        end
        else
        begin
            if (wr_buf)
                tx_shadow <= w_data[7:0];
            shadow_full <= wr_buf || (shadow_full && !load_now);
            tx_active <= next_active;
            if (tx_end_of_data_set)
                tx_end_of_data_pending <= 1'b1;
            else if (link_ev.tx_byte_done && !shadow_full)
                tx_end_of_data_pending <= 1'b0;
        end
    end

    // engine commands; load and enable driven only in run mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_cmd <= '0;
        else
        begin
            tx_cmd.load <= load_now;
            tx_cmd.data <= load_now ? tx_shadow : tx_cmd.data;
            tx_cmd.enable <= next_active && next_mode == sbhvb_pkg::PM_RUN;
            tx_cmd.underrun <= underrun;
        end
    end

    // ==========================================================
    // control bits
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_allow <= 1'b0;
            wait_clock_mode <= 1'b0;
        end
        else if (wr_ctl)
        begin
            irq_allow <= w_data[sbhvb_pkg::CTL_IRQ_ALLOW];
            wait_clock_mode <= w_data[sbhvb_pkg::CTL_WAIT_CLOCK_MODE];
        end
    end

    // ==========================================================
    // low-power modes
    // ==========================================================
    always_comb
    begin
        next_mode = mode;
        case (mode)
            sbhvb_pkg::PM_RUN:
                if (cpu_stop_exec || (cpu_wait_exec && wait_clock_mode))
                    next_mode = sbhvb_pkg::PM_STOP;
                else if (cpu_wait_exec)
                    next_mode = sbhvb_pkg::PM_WAIT;
            sbhvb_pkg::PM_WAIT:
                if (link_ev.rx_eof)
                    next_mode = sbhvb_pkg::PM_RUN;
            sbhvb_pkg::PM_STOP:
                if (bus_rise)
                    next_mode = sbhvb_pkg::PM_RESTART;
            sbhvb_pkg::PM_RESTART:
                if (clocks_stable)
                    next_mode = sbhvb_pkg::PM_RUN;
            default:
                next_mode = sbhvb_pkg::PM_RUN;
        endcase
    end

    // eof before a wait-entered stop is what makes the waking byte trustworthy
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode <= sbhvb_pkg::PM_RUN;
            bus_prev <= 1'b0;
            eof_seen <= 1'b1;
            wake_rx_ok <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            bus_prev <= bus_active;
            if (link_ev.rx_eof)
                eof_seen <= 1'b1;
            else if (bus_rise && mode == sbhvb_pkg::PM_RUN)
                eof_seen <= 1'b0;
            if (mode == sbhvb_pkg::PM_RUN && next_mode == sbhvb_pkg::PM_STOP)
                wake_rx_ok <= cpu_wait_exec && !cpu_stop_exec && eof_seen;
        end
    end

    // ==========================================================
    // interrupt lines
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_irq <= 1'b0;
            cpu_nmi <= 1'b0;
        end
        else
        begin
            cpu_irq <= code != sbhvb_pkg::EV_NONE && irq_allow;
            cpu_nmi <= stop_wake;
        end
    end

    // ==========================================================
    // axi4-lite slave: address and data taken in either order
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sbhvb_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? sbhvb_pkg::RESP_OKAY : sbhvb_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= sbhvb_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_hit ? sbhvb_pkg::RESP_OKAY : sbhvb_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    property p_vec_format;
        @(posedge aclk) disable iff (!aresetn)
        rd_vec |=> s_axi_rdata[31:6] == '0 && s_axi_rdata[1:0] == 2'h0;
    endproperty
    a_vec_format: assert property (p_vec_format)
        else $error("vector reserved bits not zero");

    property p_vec_times_four;
        @(posedge aclk) disable iff (!aresetn)
        rd_vec |=> s_axi_rdata[5:2] == $past(code) && s_axi_rvalid;
    endproperty
    a_vec_times_four: assert property (p_vec_times_four)
        else $error("vector value not four times code");

    property p_read_clears;
        @(posedge aclk) disable iff (!aresetn)
        rd_vec && code == sbhvb_pkg::EV_ARB_LOST && !link_ev.arb_lost |=> !pend[5];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("vector read left arbitration flag set");

    property p_rx_needs_data_read;
        @(posedge aclk) disable iff (!aresetn)
        rd_vec && code == sbhvb_pkg::EV_RX_FULL |=> pend[3] ##1 (pend[3] || $past(rd_buf));
    endproperty
    a_rx_needs_data_read: assert property (p_rx_needs_data_read)
        else $error("rx full cleared without data read");

    property p_priority;
        @(posedge aclk) disable iff (!aresetn)
        pend[5] && pend[8:6] == 3'h0 |-> code == sbhvb_pkg::EV_ARB_LOST;
    endproperty
    a_priority: assert property (p_priority)
        else $error("lower pending source not reported");

    property p_reload;
        @(posedge aclk) disable iff (!aresetn)
        link_ev.tx_byte_done && shadow_full && mode == sbhvb_pkg::PM_RUN
            |=> tx_cmd.load && tx_cmd.data == $past(tx_shadow);
    endproperty
    a_reload: assert property (p_reload)
        else $error("shadow byte not moved to shift register");

    property p_tx_empty;
        @(posedge aclk) disable iff (!aresetn)
        link_ev.tx_first_bit |=> pend[4];
    endproperty
    a_tx_empty: assert property (p_tx_empty)
        else $error("tx empty not set after first bit");

    property p_rx_capture;
        @(posedge aclk) disable iff (!aresetn)
        link_ev.rx_byte_valid && !link_ev.rx_is_response
            |=> rx_shadow == $past(link_ev.rx_byte) && pend[3];
    endproperty
    a_rx_capture: assert property (p_rx_capture)
        else $error("received byte not captured");

    property p_wait_silent;
        @(posedge aclk) disable iff (!aresetn)
        mode == sbhvb_pkg::PM_WAIT ##1 mode == sbhvb_pkg::PM_WAIT |-> !tx_cmd.enable;
    endproperty
    a_wait_silent: assert property (p_wait_silent)
        else $error("transmitter enabled in wait");

    property p_stop_wake;
        @(posedge aclk) disable iff (!aresetn)
        mode == sbhvb_pkg::PM_STOP && bus_active && !bus_prev
            |=> cpu_nmi && pend[8] && mode == sbhvb_pkg::PM_RESTART;
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("bus edge did not wake from stop");

    property p_irq_line;
        @(posedge aclk) disable iff (!aresetn)
        ##1 cpu_irq == ($past(code) != sbhvb_pkg::EV_NONE && $past(irq_allow));
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("interrupt line does not follow code");

endmodule : sbhvb_link_controller

// ==== sbhvb_bus_node.sv ====
// bit-engine and bus model facing the link controller
// assumes bench-injected receive events on ev_in
`timescale 1ns/1ps

module sbhvb_bus_node (
    // clock
    input wire logic aclk,
    // controller side
    input wire sbhvb_pkg::sbhvb_tx_cmd_t tx_cmd,
    input wire sbhvb_pkg::sbhvb_link_ev_t ev_in,
    output sbhvb_pkg::sbhvb_link_ev_t link_ev
);
    // ==========================================================
    // byte timing
    // ==========================================================
    logic [4:0] cnt = 5'h00;

    // sixteen cycles a byte leaves room for a refill before done
    always_ff @(posedge aclk)
    begin
        if (tx_cmd.load)
            cnt <= 5'h01;
        else if (tx_cmd.underrun || cnt == 5'h10)
            cnt <= 5'h00;
        else if (cnt != 5'h00)
            cnt <= cnt + 5'h01;
    end

    // engine pulses merged with the injected receive traffic
    always_comb
    begin
        link_ev = ev_in;
        link_ev.tx_first_bit = (cnt == 5'h02);
        link_ev.tx_byte_done = (cnt == 5'h10);
    end
endmodule : sbhvb_bus_node

// ==== test_serial_bus_host_vector_buffer.sv ====
// self-checking bench for the link controller
// assumes the bus node model as bit engine
`timescale 1ns/1ps

module test_serial_bus_host_vector_buffer;
    // ==========================================================
    // stimulus and wiring
    // ==========================================================
    localparam logic [11:0] VEC = {sbhvb_pkg::IDX_EVENT_VECTOR, 2'h0};
    localparam logic [11:0] BUF = {sbhvb_pkg::IDX_BYTE_BUFFER, 2'h0};
    localparam logic [11:0] CTL = {sbhvb_pkg::IDX_CONTROL, 2'h0};
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, bus_active = 0, clocks_stable = 1;
    logic cpu_wait_exec = 0, cpu_stop_exec = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cpu_irq, cpu_nmi, wake_rx_ok;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    sbhvb_pkg::sbhvb_link_ev_t ev = '0, link_ev;
    sbhvb_pkg::sbhvb_tx_cmd_t tx_cmd;
    int miscompares = 0, check_count = 0;

    sbhvb_link_controller dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .link_ev, .bus_active, .tx_cmd, .cpu_wait_exec, .cpu_stop_exec,
        .clocks_stable, .cpu_irq, .cpu_nmi, .wake_rx_ok);
    sbhvb_bus_node node (.aclk, .tx_cmd, .ev_in(ev), .link_ev);

    initial
    begin
        forever #10 aclk = ~aclk;
    end

    // ==========================================================
    // bus tasks and checks
    // ==========================================================
    task automatic axw(input logic [11:0] a, input logic [31:0] w);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, sbhvb_pkg::RESP_OKAY});
    endtask : axw

    task automatic axr(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk({30'h0, s_axi_rresp}, {30'h0, sbhvb_pkg::RESP_OKAY});
        d = s_axi_rdata;
    endtask : axr

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // vector reads back four times the event code
    task automatic rv(input logic [3:0] c);
        axr(VEC);
        chk(d, {26'h0, c, 2'h0});
    endtask : rv

    task automatic step(input int n);
        repeat (n) @(posedge aclk);
        ev <= '0;
        cpu_wait_exec <= 1'b0;
        cpu_stop_exec <= 1'b0;
        @(posedge aclk);
    endtask : step

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_rx;
        axw(CTL, 32'h1);
        ev.rx_byte_valid <= 1'b1;
        ev.rx_byte <= 8'hA5;
        step(1);
        @(posedge aclk);
        chk({31'h0, cpu_irq}, 32'h1);
        rv(4'h3);
        rv(4'h3);
        axr(BUF);
        chk(d, 32'hA5);
        rv(4'h0);
        chk({31'h0, cpu_irq}, 32'h0);
        ev.rx_byte_valid <= 1'b1;
        ev.rx_is_response <= 1'b1;
        ev.rx_byte <= 8'h3C;
        step(1);
        rv(4'h2);
        axr(BUF);
        chk(d, 32'h3C);
        rv(4'h0);
        $display("t_rx done");
    endtask : t_rx

    task automatic t_prio;
        ev.crc_err <= 1'b1;
        ev.arb_lost <= 1'b1;
        ev.rx_eof <= 1'b1;
        step(1);
        rv(4'h6);
        rv(4'h5);
        rv(4'h1);
        rv(4'h0);
        $display("t_prio done");
    endtask : t_prio

    task automatic t_tx;
        axw(BUF, 32'h3C);
        while (!tx_cmd.load) @(posedge aclk);
        chk({23'h0, tx_cmd.enable, tx_cmd.data}, 32'h13C);
        repeat (3) @(posedge aclk);
        rv(4'h4);
        axw(BUF, 32'h5A);
        rv(4'h0);
        while (!tx_cmd.load) @(posedge aclk);
        chk({24'h0, tx_cmd.data}, 32'h5A);
        while (!tx_cmd.underrun) @(posedge aclk);
        @(posedge aclk);
        chk({31'h0, tx_cmd.enable}, 32'h0);
        rv(4'h7);
        rv(4'h4);
        axw(CTL, 32'h5);
        rv(4'h0);
        $display("t_tx done");
    endtask : t_tx

    task automatic t_power;
        axw(CTL, 32'h0);
        cpu_wait_exec <= 1'b1;
        step(1);
        ev.rx_eof <= 1'b1;
        step(1);
        rv(4'h1);
        axw(CTL, 32'h2);
        cpu_wait_exec <= 1'b1;
        step(1);
        chk({31'h0, wake_rx_ok}, 32'h1);
        clocks_stable <= 1'b0;
        bus_active <= 1'b1;
        while (!cpu_nmi) @(posedge aclk);
        clocks_stable <= 1'b1;
        bus_active <= 1'b0;
        step(1);
        rv(4'h8);
        rv(4'h0);
        cpu_stop_exec <= 1'b1;
        step(1);
        chk({31'h0, wake_rx_ok}, 32'h0);
        $display("t_power done");
    endtask : t_power

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rv(4'h0);
        t_rx();
        t_prio();
        t_tx();
        t_power();
        end_sim();
    end

    // watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        end_sim();
    end
endmodule : test_serial_bus_host_vector_buffer
